// ### aca_top.sv
// Purpose: conversion sequencing, digital comparator, alert pin, alert reply
// Assumes: converter core delivers a signed code on conv_result at conv_done
// Notes: alert and sda pins are open drain; oe high pulls the line low
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module aca_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] conv_result,
  output logic conv_power,
  output logic mod_tick,
  output logic conv_done,
  output logic [2:0] gain_range_select,
  input wire logic [6:0] target_address,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alert_o,
  output logic alert_oe
);
  aca_pkg::aca_cfg_t cfg, next_cfg;
  logic [15:0] lower_limit, next_lower_limit;
  logic [15:0] upper_limit, next_upper_limit;
  logic [15:0] result, next_result;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic trig_req;
  logic rd_result;
  logic bus_take;
  aca_pkg::aca_conv_t cv_state, next_cv_state;
  logic alert_active, next_alert_active;
  logic status_hi, next_status_hi;
  logic ready_mode;

  // Register bus
  assign bus_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_comb begin
    next_cfg = cfg;
    next_lower_limit = lower_limit;
    next_upper_limit = upper_limit;
    next_wb_ack_o = bus_take;
    next_wb_dat_o = 32'h0;
    trig_req = 1'b0;
    rd_result = 1'b0;
    if (bus_take && wb_we_i) begin
      unique case (wb_adr_i)
        aca_pkg::OFS_CONFIG: begin
          if (wb_sel_i[0]) begin
            next_cfg.rate_select = wb_dat_i[7:5];
            next_cfg.window_mode = wb_dat_i[4];
            next_cfg.alert_polarity = wb_dat_i[3];
            next_cfg.alert_latch_enable = wb_dat_i[2];
            next_cfg.fault_queue_count = wb_dat_i[1:0];
          end
          if (wb_sel_i[1]) begin
            next_cfg.gain_range_select = wb_dat_i[11:9]; // see R4
            next_cfg.single_mode = wb_dat_i[8];
            trig_req = wb_dat_i[15]; // see R20
          end
        end
        aca_pkg::OFS_LOWER: begin
          if (wb_sel_i[0]) next_lower_limit[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_lower_limit[15:8] = wb_dat_i[15:8];
        end
        aca_pkg::OFS_UPPER: begin
          if (wb_sel_i[0]) next_upper_limit[7:0] = wb_dat_i[7:0];
          if (wb_sel_i[1]) next_upper_limit[15:8] = wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end else if (bus_take) begin
      unique case (wb_adr_i)
        aca_pkg::OFS_RESULT: begin
          next_wb_dat_o = {16'h0, result}; // see R19
          rd_result = 1'b1;
        end
        aca_pkg::OFS_CONFIG: next_wb_dat_o = {16'h0,
          cv_state == aca_pkg::CV_IDLE, 3'h0, cfg};
        aca_pkg::OFS_LOWER: next_wb_dat_o = {16'h0, lower_limit};
        aca_pkg::OFS_UPPER: next_wb_dat_o = {16'h0, upper_limit};
        aca_pkg::OFS_STATUS: next_wb_dat_o = {28'h0, ready_mode,
          status_hi, alert_active, cv_state != aca_pkg::CV_IDLE};
        default: next_wb_dat_o = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg <= aca_pkg::CFG_RESET;
      lower_limit <= aca_pkg::LOWER_RESET;
      upper_limit <= aca_pkg::UPPER_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      cfg <= next_cfg;
      lower_limit <= next_lower_limit;
      upper_limit <= next_upper_limit;
      wb_ack_o <= next_wb_ack_o;
      wb_dat_o <= next_wb_dat_o;
    end
  end

  // Oscillator and modulator dividers
  logic [6:0] osc_cnt, next_osc_cnt;
  logic [1:0] mod_cnt, next_mod_cnt;
  logic next_mod_tick;
  always_comb begin
    next_osc_cnt = osc_cnt + 7'h1;
    next_mod_cnt = mod_cnt;
    next_mod_tick = 1'b0;
    if (osc_cnt == 7'(aca_pkg::OSC_CYCLES - 1)) begin
      next_osc_cnt = 7'h0;
      next_mod_cnt = mod_cnt + 2'h1; // see R1
      next_mod_tick = (mod_cnt == 2'(aca_pkg::MOD_DIV - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_cnt <= 7'h0;
      mod_cnt <= 2'h0;
      mod_tick <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      mod_cnt <= next_mod_cnt;
      mod_tick <= next_mod_tick;
    end
  end

  // Conversion sequencer
  logic [11:0] cv_cnt, next_cv_cnt;
  logic [11:0] cv_len, next_cv_len;
  logic cv_single, next_cv_single;
  logic next_conv_done, next_conv_power;
  always_comb begin
    next_cv_state = cv_state;
    next_cv_cnt = cv_cnt;
    next_cv_len = cv_len;
    next_cv_single = cv_single;
    next_conv_done = 1'b0;
    next_result = result;
    unique case (cv_state)
      aca_pkg::CV_IDLE: begin
        if (!cfg.single_mode || trig_req) begin
          next_cv_state = aca_pkg::CV_WAKE; // see R20
          next_cv_cnt = 12'h0;
          next_cv_single = cfg.single_mode;
        end
      end
      aca_pkg::CV_WAKE: begin
        next_cv_cnt = cv_cnt + 12'h1;
        if (cv_cnt == 12'(aca_pkg::WAKE_CYCLES - 1)) begin
          next_cv_state = aca_pkg::CV_RUN;
          next_cv_cnt = 12'h0;
          next_cv_len = aca_pkg::conv_ticks(cfg.rate_select); // see R2
        end
      end
      aca_pkg::CV_RUN: begin
        if (mod_tick) next_cv_cnt = cv_cnt + 12'h1;
        if (mod_tick && cv_cnt == cv_len - 12'h1) begin
          next_conv_done = 1'b1; // see R3
          next_result = conv_result;
          next_cv_cnt = 12'h0;
          if (cv_single || cfg.single_mode) begin
            next_cv_state = aca_pkg::CV_IDLE;
          end else begin
            next_cv_len = aca_pkg::conv_ticks(cfg.rate_select); // see R19
          end
        end
      end
      default: next_cv_state = aca_pkg::CV_IDLE;
    endcase
    next_conv_power = next_cv_state != aca_pkg::CV_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cv_state <= aca_pkg::CV_IDLE;
      cv_cnt <= 12'h0;
      cv_len <= 12'h0;
      cv_single <= 1'b1;
      conv_done <= 1'b0;
      conv_power <= 1'b0;
      result <= 16'h0;
      gain_range_select <= aca_pkg::CFG_RESET.gain_range_select;
    end else begin
      cv_state <= next_cv_state;
      cv_cnt <= next_cv_cnt;
      cv_len <= next_cv_len;
      cv_single <= next_cv_single;
      conv_done <= next_conv_done;
      conv_power <= next_conv_power;
      result <= next_result;
      gain_range_select <= cfg.gain_range_select; // see R5
    end
  end

  // Comparator, fault queue and alert pin
  logic [2:0] q_cnt, next_q_cnt;
  logic [9:0] pulse_cnt, next_pulse_cnt;
  logic rdy_hold, next_rdy_hold;
  logic above, below, hit, reach, asserted;
  logic [2:0] need;
  logic smb_win;
  logic next_alert_oe;
  assign ready_mode = upper_limit[15] && !lower_limit[15] &&
                      cfg.fault_queue_count != aca_pkg::QUEUE_OFF; // see R12
  assign above = $signed(result) > $signed(upper_limit);
  assign below = $signed(result) < $signed(lower_limit);
  always_comb begin
    next_alert_active = alert_active;
    next_status_hi = status_hi;
    next_q_cnt = q_cnt;
    next_pulse_cnt = pulse_cnt;
    next_rdy_hold = rdy_hold;
    need = 3'h1 << cfg.fault_queue_count; // see R10
    hit = cfg.window_mode ? (above || below) : above;
    reach = (q_cnt + 3'h1) >= need;
    if (cfg.alert_latch_enable && (rd_result || smb_win)) begin
      next_alert_active = 1'b0; // see R9
    end
    if (cfg.fault_queue_count == aca_pkg::QUEUE_OFF || ready_mode) begin
      next_alert_active = 1'b0;
      next_q_cnt = 3'h0;
    end else if (conv_done) begin
      next_q_cnt = hit ? (reach ? q_cnt : q_cnt + 3'h1) : 3'h0; // see R21
      if (hit && reach) begin
        next_alert_active = 1'b1; // see R15
        next_status_hi = above; // see R18
      end else if (!cfg.alert_latch_enable) begin
        if (cfg.window_mode) next_alert_active = 1'b0; // see R7
        else if (below) next_alert_active = 1'b0; // see R6
      end
    end
    if (pulse_cnt != 10'h0) next_pulse_cnt = pulse_cnt - 10'h1;
    if (trig_req && cv_state == aca_pkg::CV_IDLE) next_rdy_hold = 1'b0;
    if (conv_done && ready_mode) begin
      if (cv_single) next_rdy_hold = 1'b1; // see R14
      else next_pulse_cnt = 10'(aca_pkg::PULSE_CYCLES); // see R13
    end
    asserted = ready_mode ? (rdy_hold || pulse_cnt != 10'h0) : alert_active;
    // Open drain: only a low level is driven
    next_alert_oe = (asserted != cfg.alert_polarity); // see R8
    if (cfg.fault_queue_count == aca_pkg::QUEUE_OFF) begin
      next_alert_oe = 1'b0; // see R11
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      alert_active <= 1'b0;
      status_hi <= 1'b0;
      q_cnt <= 3'h0;
      pulse_cnt <= 10'h0;
      rdy_hold <= 1'b0;
      alert_oe <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      alert_active <= next_alert_active;
      status_hi <= next_status_hi;
      q_cnt <= next_q_cnt;
      pulse_cnt <= next_pulse_cnt;
      rdy_hold <= next_rdy_hold;
      alert_oe <= next_alert_oe;
      alert_o <= 1'b0;
    end
  end

  // Alert response target on the serial bus
  logic [2:0] scl_sy, sda_sy;
  logic [6:0] addr_s1, addr_s2;
  aca_pkg::aca_smb_t sm_state, next_sm_state;
  logic [7:0] sh, next_sh;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic next_sda_oe;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_sy[1] && !scl_sy[2];
  assign scl_fall = !scl_sy[1] && scl_sy[2];
  assign bus_start = scl_sy[1] && sda_sy[2] && !sda_sy[1];
  assign bus_stop = scl_sy[1] && !sda_sy[2] && sda_sy[1];
  always_comb begin
    next_sm_state = sm_state;
    next_sh = sh;
    next_bit_cnt = bit_cnt;
    next_sda_oe = sda_oe;
    smb_win = 1'b0;
    if (bus_start) begin
      next_sm_state = aca_pkg::SM_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_sm_state = aca_pkg::SM_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (sm_state)
        aca_pkg::SM_IDLE: next_sda_oe = 1'b0;
        aca_pkg::SM_ADDR: begin
          if (scl_rise) begin
            next_sh = {sh[6:0], sda_sy[1]};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (scl_fall && bit_cnt == 4'h8) begin
            if (sh == aca_pkg::ALERT_RESP_ADDR && alert_active &&
                cfg.alert_latch_enable) begin
              next_sm_state = aca_pkg::SM_ACK; // see R16
              next_sda_oe = 1'b1;
            end else begin
              next_sm_state = aca_pkg::SM_IDLE;
            end
          end
        end
        aca_pkg::SM_ACK: begin
          if (scl_fall) begin
            next_sm_state = aca_pkg::SM_SEND;
            next_sh = {addr_s2, status_hi};
            next_sda_oe = !addr_s2[6];
            next_bit_cnt = 4'h0;
          end
        end
        aca_pkg::SM_SEND: begin
          if (scl_rise) begin
            if (sh[7] && !sda_sy[1]) begin
              next_sm_state = aca_pkg::SM_IDLE; // see R17
              next_sda_oe = 1'b0;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
              if (bit_cnt == 4'h7) begin
                smb_win = 1'b1; // see R17
                next_sm_state = aca_pkg::SM_DONE;
              end
            end
          end else if (scl_fall) begin
            next_sh = {sh[6:0], 1'b0};
            next_sda_oe = !sh[6];
          end
        end
        aca_pkg::SM_DONE: begin
          if (scl_fall) begin
            next_sm_state = aca_pkg::SM_IDLE;
            next_sda_oe = 1'b0;
          end
        end
        default: next_sm_state = aca_pkg::SM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      addr_s1 <= 7'h0;
      addr_s2 <= 7'h0;
      sm_state <= aca_pkg::SM_IDLE;
      sh <= 8'h0;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_sy <= {scl_sy[1:0], scl_i};
      sda_sy <= {sda_sy[1:0], sda_i};
      addr_s1 <= target_address;
      addr_s2 <= addr_s1;
      sm_state <= next_sm_state;
      sh <= next_sh;
      bit_cnt <= next_bit_cnt;
      sda_oe <= next_sda_oe;
      sda_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### aca_pkg.sv
// Purpose: constants, types and conversion table for the alert control block
// Assumes: clk at 100 MHz; registers reached over classic Wishbone
// Notes on behaviour
// R1: Modulator tick is the 1 MHz oscillator divided by four, 250 kHz.
// R2: Three-bit rate field picks one of seven output data rates.
// R3: Conversion lasts one period of the selected data rate.
// R4: Three-bit gain field picks one of six full-scale ranges.
// R5: One code step is the full-scale range over two to the sixteenth.
// R6: Traditional mode asserts above upper limit, releases below lower limit.
// R7: Window mode asserts while result is above upper or below lower.
// R8: Polarity bit picks asserted alert level; default is active low.
// R9: Latched alert holds until result read or won alert response.
// R10: Queue field needs one, two or four hits; last code disables.
// R11: Disabled comparator releases the open-drain alert pin high.
// R12: Limit sign bits 1 and 0 with queue enabled select ready mode.
// R13: Ready mode, continuous: about 8 us pulse after every conversion.
// R14: Ready mode, single-shot: alert drives asserted level at conversion end.
// R15: Cleared latch reasserts on later violation; conversions stay untouched.
// R16: Alert response address answered with own address when alert asserted; the code answers only while a latched comparator alert is active.
// R17: Lowest address wins arbitration and clears; losers keep their alert.
// R18: Window mode status bit is 1 for upper, 0 for lower violation.
// R19: Continuous mode restarts at once; reads give latest result.
// R20: Single-shot start powers up 25 us, runs one conversion, powers down.
// R21: Comparator and queue evaluated once per completed conversion.
package aca_pkg;
  localparam logic [4:0] OFS_RESULT = 5'h00;
  localparam logic [4:0] OFS_CONFIG = 5'h04;
  localparam logic [4:0] OFS_LOWER = 5'h08;
  localparam logic [4:0] OFS_UPPER = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int MOD_DIV = 4;
  localparam int OSC_CYCLES = CLK_HZ / OSC_HZ;
  localparam int WAKE_US = 25;
  localparam int WAKE_CYCLES = WAKE_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_US = 8;
  localparam int PULSE_CYCLES = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int MOD_HZ = OSC_HZ / MOD_DIV;
  localparam logic [7:0] ALERT_RESP_ADDR = 8'h19;
  localparam logic [1:0] QUEUE_OFF = 2'h3;
  localparam logic [15:0] LOWER_RESET = 16'h8000;
  localparam logic [15:0] UPPER_RESET = 16'h7fff;

  typedef struct packed {
    logic [2:0] gain_range_select;
    logic single_mode;
    logic [2:0] rate_select;
    logic window_mode;
    logic alert_polarity;
    logic alert_latch_enable;
    logic [1:0] fault_queue_count;
  } aca_cfg_t;

  localparam aca_cfg_t CFG_RESET = '{3'h2, 1'b1, 3'h4, 1'b0, 1'b0, 1'b0,
                                     2'h3};

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_WAKE = 2'b01,
    CV_RUN = 2'b10
  } aca_conv_t;

  typedef enum logic [2:0] {
    SM_IDLE = 3'b000,
    SM_ADDR = 3'b001,
    SM_ACK = 3'b010,
    SM_SEND = 3'b011,
    SM_DONE = 3'b100
  } aca_smb_t;

  // Modulator ticks per conversion for each data rate
  function automatic logic [11:0] conv_ticks(input logic [2:0] rate);
    int sps;
    sps = 3300;
    unique case (rate)
      3'h0: sps = 128;
      3'h1: sps = 250;
      3'h2: sps = 490;
      3'h3: sps = 920;
      3'h4: sps = 1600;
      3'h5: sps = 2400;
      default: sps = 3300;
    endcase
    conv_ticks = 12'(MOD_HZ / sps);
  endfunction
endpackage

// ### aca_checker.sv
// Purpose: port assertions for the alert control block
// Assumes: bound into aca_top; config fields shadowed from bus writes
// Notes: conversion lengths come from a local table of tick counts
`timescale 1ns/1ns
`default_nettype none
module aca_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic conv_power,
  input wire logic mod_tick,
  input wire logic conv_done,
  input wire logic [2:0] gain_range_select,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alert_o,
  input wire logic alert_oe
);
  localparam int TK [8] = '{1953, 1000, 510, 271, 156, 104, 75, 75};
  logic wr_cfg;
  logic q_off;
  logic seen;
  logic [2:0] rate;
  logic [2:0] gain_exp;
  logic [8:0] gap;
  logic [11:0] runs;
  assign wr_cfg = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
                  wb_adr_i == 5'h04;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_off <= 1'b1;
      seen <= 1'b0;
      rate <= 3'h4;
      gain_exp <= 3'h2;
      gap <= 9'h0;
      runs <= 12'h0;
    end else begin
      gap <= mod_tick ? 9'h0 : gap + 9'h1;
      seen <= seen || mod_tick;
      runs <= (!conv_power || conv_done) ? 12'h0 : runs + 12'(mod_tick);
      if (wr_cfg && wb_sel_i[0]) begin
        q_off <= wb_dat_i[1:0] == 2'h3;
        rate <= wb_dat_i[7:5];
      end
      if (wr_cfg && wb_sel_i[1]) begin
        gain_exp <= wb_dat_i[11:9];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_timing_a:
    assert property (taken_s |=> answer_s)
    else $error("bus request not answered after one cycle");
  tick_rate_a:
    assert property (mod_tick && seen |-> gap == 9'h18f)
    else $error("modulator tick period wrong");
  conv_time_a:
    assert property (conv_done |-> runs + 12'h1 >= TK[rate] &&
                     runs <= TK[rate] + 8)
    else $error("conversion length wrong for rate");
  gain_copy_a:
    assert property (wr_cfg && wb_sel_i[1] |->
                     ##2 gain_range_select == gain_exp)
    else $error("gain output not following config");
  queue_off_a:
    assert property (q_off && $past(q_off, 2) |-> !alert_oe)
    else $error("alert pulled while comparator off");
  open_drain_a:
    assert property (!alert_o && !sda_o)
    else $error("open drain output driven high");
  sda_change_a:
    assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line changed while clock high");
  done_power_a:
    assert property ($rose(conv_power) |=> (conv_power && !conv_done)[*8])
    else $error("power up not followed by wake time");
endmodule
bind aca_top aca_checker u_chk (.clk(clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .conv_power(conv_power), .mod_tick(mod_tick),
  .conv_done(conv_done), .gain_range_select(gain_range_select),
  .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
  .alert_oe(alert_oe));
`default_nettype wire

// ### aca_host.sv
// Purpose: serial host that answers the alert line with alert responses
// Assumes: bench resolves SDA with a pull-up; SCL rests high between frames
// Notes: rival byte pulls SDA low as a lower-addressed device would
`timescale 1ns/1ns
`default_nettype none
module aca_host #(
  parameter int HALF = 20
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  localparam logic [7:0] RESP_ADDR = 8'h19;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Data moves a little after SCL falls so no edge looks like START/STOP
  task automatic bit_io(input logic pull, output logic got);
    repeat (2) @(posedge clk);
    sda_oe <= pull;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    got = sda;
    scl <= 1'b0;
  endtask
  task automatic alert_resp(input logic [7:0] rival,
      output logic [7:0] got, output logic acked);
    logic b;
    sda_oe <= 1'b1;
    repeat (HALF) @(posedge clk);
    scl <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!RESP_ADDR[i], b);
    end
    bit_io(1'b0, b);
    acked = !b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(!rival[i], got[i]);
    end
    bit_io(1'b0, b);
    repeat (2) @(posedge clk);
    sda_oe <= 1'b1;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_oe <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### aca_top_tb.sv
// Purpose: self-checking bench for the alert control block
// Assumes: bench plays converter core, register master and serial host
// Notes: fastest rate keeps each single-shot run near 33k cycles
`timescale 1ns/1ns
`default_nettype none
module aca_top_tb;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ack, pwr, tick, done, scl, sda, sda_o, sda_oe, al_o, al_oe, h_oe;
  logic a_ok;
  logic [4:0] adr = 5'h0;
  logic [31:0] dw = 32'h0, lf = 32'hf270;
  logic [31:0] dr, q;
  logic [15:0] res = 16'h0;
  logic [6:0] taddr = 7'h40;
  logic [2:0] gain, g;
  logic [7:0] got;
  int errors = 0, check_count = 0, cycles = 0;
  assign sda = !(sda_oe || h_oe);
  aca_top dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .conv_result(res), .conv_power(pwr),
    .mod_tick(tick), .conv_done(done), .gain_range_select(gain),
    .target_address(taddr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_o(al_o), .alert_oe(al_oe));
  aca_host host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
  initial forever #5 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Config word: single shot at the fastest rate, polarity active low
  function automatic logic [31:0] cfg(input logic st, input logic [2:0] gn,
      input logic win, input logic lat, input logic [1:0] qc);
    cfg = {16'h0, st, 3'h0, gn, 1'b1, 3'h6, win, 1'b0, lat, qc};
  endfunction
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    check_count++;
    if (gv !== ev) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, gv, ev);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wait_done();
    while (done !== 1'b1) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(5'h04, 32'h8583);
    rdc(5'h08, 32'h8000);
    rdc(5'h0c, 32'h7fff);
    rdc(5'h14, 32'h0);
    chk({31'h0, al_oe}, 32'h0);
    $display("test reset done");
    lf = nxt(nxt(lf));
    g = 3'(lf[7:0] % 8'h6);
    res <= {2'b01, lf[21:8]};
    taddr <= {1'b1, lf[27:22]};
    bus(1'b1, 5'h0c, 32'h3fff);
    bus(1'b1, 5'h08, 32'hc000);
    bus(1'b1, 5'h04, cfg(1'b1, g, 1'b1, 1'b1, 2'h0));
    bus(1'b1, 5'h04, cfg(1'b1, g, 1'b1, 1'b1, 2'h0));
    rdc(5'h10, 32'h1);
    chk({29'h0, gain}, {29'h0, g});
    wait_done();
    chk({31'h0, pwr}, 32'h0);
    chk({31'h0, al_oe}, 32'h1);
    rdc(5'h10, 32'h6);
    host.alert_resp(8'h01, got, a_ok);
    chk({31'h0, al_oe}, 32'h1);
    host.alert_resp(8'hff, got, a_ok);
    chk({31'h0, a_ok}, 32'h1);
    chk({24'h0, got}, {24'h0, taddr, 1'b1});
    chk({31'h0, al_oe}, 32'h0);
    rdc(5'h00, {16'h0, res});
    $display("test window latch done");
    lf = nxt(lf);
    bus(1'b1, 5'h0c, 32'h8000);
    bus(1'b1, 5'h08, 32'h7fff);
    res <= lf[31:16];
    bus(1'b1, 5'h04, cfg(1'b1, g, 1'b0, 1'b1, 2'h1));
    chk({31'h0, al_oe}, 32'h0);
    wait_done();
    chk({31'h0, al_oe}, 32'h1);
    bus(1'b1, 5'h04, cfg(1'b0, g, 1'b0, 1'b1, 2'h3));
    repeat (4) @(posedge clk);
    chk({31'h0, al_oe}, 32'h0);
    $display("test ready mode done");
    results();
  end
endmodule
`default_nettype wire
